// file: src/mqfb_defines.svh
// constants of the multi-queue flag bus and packet status block
`ifndef MQFB_DEFINES_SVH
`define MQFB_DEFINES_SVH
`define MQFB_NUM_Q 32
`define MQFB_QUAD_W 8
`define MQFB_LVL_W 16
`define MQFB_LVL_MAX 16'hFFFF
`define MQFB_THR_RST 16'h0008
`define MQFB_NUMQ_RST 6'h20
`define MQFB_REG_CTRL 10'h000
`define MQFB_REG_STAT 10'h004
`define MQFB_RGN_CSR 2'h0
`define MQFB_RGN_AE 2'h1
`define MQFB_RGN_AF 2'h2
`define MQFB_RGN_LVL 2'h3
`define MQFB_POLL_Q_RST 2'h3
`define MQFB_LOAD_CNT 2'h2
`endif

// file: src/mqfb_pkg.sv
// types of the multi-queue flag bus and packet status block
`default_nettype none
package mqfb_pkg;
  typedef struct packed {
    logic wr_clk;
    logic rd_clk;
    logic wr_en_n;
    logic rd_en_n;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    logic wr_quad_strobe;
    logic rd_quad_strobe;
    logic [35:0] din;
    logic [2:0] device_id;
    logic flag_bus_mode_select;
    logic width_match_select;
    logic input_width_select;
    logic output_width_select;
  } mqfb_pins_t;
endpackage
`default_nettype wire

// file: src/mqfb_top.sv
// flag status busses, queue levels and packet status of a 32-queue fifo
`timescale 1ns/1ps
`include "mqfb_defines.svh"
`default_nettype none
module mqfb_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire mqfb_pkg::mqfb_pins_t pins,
  input wire logic rd_word_end,
  output logic [7:0] almost_full_status_bus,
  output logic [7:0] almost_empty_status_bus,
  output logic packet_ready_n,
  output logic output_valid_n
);
  mqfb_pkg::mqfb_pins_t pin_s1_r;
  mqfb_pkg::mqfb_pins_t pin_s2_r;
  logic wr_clk_d_r;
  logic rd_clk_d_r;
  logic wr_tick;
  logic rd_tick;
  logic [1:0] load_cnt_r;
  logic cfg_loaded_r;
  logic polled_r;
  logic width36_r;
  logic pkt_en_r;
  logic [5:0] num_q_r;
  logic packet_mode;
  logic [`MQFB_LVL_W-1:0] lvl_r [`MQFB_NUM_Q];
  logic [`MQFB_LVL_W-1:0] pkt_cnt_r [`MQFB_NUM_Q];
  logic [`MQFB_LVL_W-1:0] ae_thr_r [`MQFB_NUM_Q];
  logic [`MQFB_LVL_W-1:0] af_thr_r [`MQFB_NUM_Q];
  logic [`MQFB_NUM_Q-1:0] af_vec;
  logic [`MQFB_NUM_Q-1:0] ae_vec;
  logic [4:0] wq;
  logic [4:0] rq;
  logic wr_hit;
  logic rd_hit;
  logic wr_fire;
  logic rd_fire;
  logic wr_end_mark;
  logic [1:0] af_quad_r;
  logic [1:0] ae_quad_r;
  logic [1:0] af_quad_nxt;
  logic [1:0] ae_quad_nxt;
  logic acc_wr;
  logic acc_rd;
  logic acc_ok;
  logic [1:0] rgn;
  logic [4:0] idx;
  logic [31:0] rd_mux;

  // pins cross from the board into ref_clk through two flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      wr_clk_d_r <= 1'b0;
      rd_clk_d_r <= 1'b0;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      wr_clk_d_r <= pin_s2_r.wr_clk;
      rd_clk_d_r <= pin_s2_r.rd_clk;
    end
  end

  // port clocks become one-cycle enables; they must run well below ref_clk / 4
  assign wr_tick = cfg_loaded_r && pin_s2_r.wr_clk && !wr_clk_d_r;
  assign rd_tick = cfg_loaded_r && pin_s2_r.rd_clk && !rd_clk_d_r;

  // straps caught after release, once the synchronisers hold real pin levels
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_cnt_r <= 2'h0;
      cfg_loaded_r <= 1'b0;
      polled_r <= 1'b0;
      width36_r <= 1'b0;
    end else if (!cfg_loaded_r) begin
      load_cnt_r <= load_cnt_r + 2'h1;
      if (load_cnt_r == `MQFB_LOAD_CNT) begin
        cfg_loaded_r <= 1'b1;
        polled_r <= pin_s2_r.flag_bus_mode_select;
        width36_r <= !pin_s2_r.width_match_select && !pin_s2_r.input_width_select
                     && !pin_s2_r.output_width_select;
      end
    end
  end

  assign packet_mode = pkt_en_r && width36_r;

  // upper address bits pick one of up to eight parallel devices
  assign wq = pin_s2_r.wr_addr[4:0];
  assign rq = pin_s2_r.rd_addr[4:0];
  assign wr_hit = pin_s2_r.wr_addr[7:5] == pin_s2_r.device_id;
  assign rd_hit = pin_s2_r.rd_addr[7:5] == pin_s2_r.device_id;
  assign wr_fire = wr_tick && !pin_s2_r.wr_en_n && wr_hit && lvl_r[wq] != `MQFB_LVL_MAX;
  assign rd_fire = rd_tick && !pin_s2_r.rd_en_n && rd_hit && lvl_r[rq] != '0;
  assign wr_end_mark = packet_mode && pin_s2_r.din[35];

  // per-queue level, packet count and flags
  genvar gi;
  generate
    for (gi = 0; gi < `MQFB_NUM_Q; gi++) begin : g_q
      logic inc;
      logic dec;
      logic pinc;
      logic pdec;
      assign inc = wr_fire && wq == 5'(gi);
      assign dec = rd_fire && rq == 5'(gi);
      assign pinc = inc && wr_end_mark;
      assign pdec = dec && packet_mode && rd_word_end && pkt_cnt_r[gi] != '0;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          lvl_r[gi] <= '0;
        end else if (inc != dec) begin
          lvl_r[gi] <= inc ? lvl_r[gi] + 16'h0001 : lvl_r[gi] - 16'h0001;
        end
      end
      // counts complete packets; start marker needs no state of its own
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pkt_cnt_r[gi] <= '0;
        end else if (!packet_mode) begin
          pkt_cnt_r[gi] <= '0;
        end else if (pinc != pdec) begin
          pkt_cnt_r[gi] <= pinc ? pkt_cnt_r[gi] + 16'h0001 : pkt_cnt_r[gi] - 16'h0001;
        end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ae_thr_r[gi] <= `MQFB_THR_RST;
          af_thr_r[gi] <= `MQFB_THR_RST;
        end else if (acc_wr && acc_ok && idx == 5'(gi)) begin
          if (rgn == `MQFB_RGN_AE) begin
            ae_thr_r[gi] <= avs_writedata[15:0];
          end
          if (rgn == `MQFB_RGN_AF) begin
            af_thr_r[gi] <= avs_writedata[15:0];
          end
        end
      end
      // unconfigured queues read inactive, a safe pick for don't care
      assign af_vec[gi] = 6'(gi) < num_q_r && lvl_r[gi] >= af_thr_r[gi];
      assign ae_vec[gi] = 6'(gi) < num_q_r && (packet_mode ? pkt_cnt_r[gi] != '0
                          : lvl_r[gi] <= ae_thr_r[gi]);
    end
  endgenerate

  // quadrant selection: polled steps and wraps, direct follows the address
  always_comb begin
    af_quad_nxt = af_quad_r;
    ae_quad_nxt = ae_quad_r;
    if (polled_r) begin
      af_quad_nxt = af_quad_r + 2'h1;
      ae_quad_nxt = ae_quad_r + 2'h1;
    end else begin
      if (pin_s2_r.wr_quad_strobe && wr_hit) begin
        af_quad_nxt = pin_s2_r.wr_addr[4:3];
      end
      if (pin_s2_r.rd_quad_strobe && rd_hit) begin
        ae_quad_nxt = pin_s2_r.rd_addr[4:3];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      af_quad_r <= `MQFB_POLL_Q_RST;
      almost_full_status_bus <= 8'hFF;
    end else if (wr_tick) begin
      af_quad_r <= af_quad_nxt;
      almost_full_status_bus <= ~af_vec[af_quad_nxt*8 +: 8];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ae_quad_r <= `MQFB_POLL_Q_RST;
      almost_empty_status_bus <= 8'hFF;
    end else if (rd_tick) begin
      ae_quad_r <= ae_quad_nxt;
      almost_empty_status_bus <= ~ae_vec[ae_quad_nxt*8 +: 8];
    end
  end

  // read port flags of the selected queue, refreshed every ref_clk
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      output_valid_n <= 1'b1;
      packet_ready_n <= 1'b1;
    end else begin
      output_valid_n <= !(rd_hit && lvl_r[rq] != '0);
      packet_ready_n <= !(packet_mode && rd_hit && pkt_cnt_r[rq] != '0);
    end
  end

  // avalon slave: one wait cycle, then the access completes
  assign acc_wr = avs_write && !avs_waitrequest;
  assign acc_rd = avs_read && avs_waitrequest;
  assign rgn = avs_address[9:8];
  assign idx = avs_address[6:2];
  // holes above each table and unaligned offsets must not alias onto a queue
  assign acc_ok = !avs_address[7] && avs_address[1:0] == 2'h0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pkt_en_r <= 1'b0;
      num_q_r <= `MQFB_NUMQ_RST;
    end else if (acc_wr && avs_address == `MQFB_REG_CTRL) begin
      pkt_en_r <= avs_writedata[0];
      num_q_r <= avs_writedata[13:8];
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (rgn)
      `MQFB_RGN_CSR: begin
        if (avs_address == `MQFB_REG_CTRL) begin
          rd_mux = {18'h00000, num_q_r, 7'h00, pkt_en_r};
        end else if (avs_address == `MQFB_REG_STAT) begin
          rd_mux = {24'h000000, ae_quad_r, af_quad_r, packet_mode, cfg_loaded_r,
                    width36_r, polled_r};
        end
      end
      `MQFB_RGN_AE: rd_mux = {16'h0000, ae_thr_r[idx]};
      `MQFB_RGN_AF: rd_mux = {16'h0000, af_thr_r[idx]};
      `MQFB_RGN_LVL: rd_mux = {16'h0000, lvl_r[idx]};
      default: rd_mux = 32'h00000000;
    endcase
    if (avs_address[7] || avs_address[1:0] != 2'h0) begin
      rd_mux = 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (acc_rd) begin
      avs_readdata <= rd_mux;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_af_step;
    polled_r && wr_tick |=> af_quad_r == 2'($past(af_quad_r) + 2'h1);
  endproperty
  a_af_step: assert property (p_af_step) else $error("af quadrant did not step");

  property p_ae_step;
    polled_r && rd_tick |=> ae_quad_r == 2'($past(ae_quad_r) + 2'h1)
      && almost_empty_status_bus == ~$past(ae_vec[ae_quad_nxt*8 +: 8]);
  endproperty
  a_ae_step: assert property (p_ae_step) else $error("ae bus not on rd edge");

  property p_wrap;
    polled_r && wr_tick && af_quad_r == 2'h3 |=> af_quad_r == 2'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("quadrant did not wrap");

  property p_hold;
    !polled_r && !(wr_tick && pin_s2_r.wr_quad_strobe) |=> $stable(af_quad_r);
  endproperty
  a_hold: assert property (p_hold) else $error("direct quadrant moved");

  property p_direct;
    !polled_r && rd_tick && pin_s2_r.rd_quad_strobe && rd_hit
      |=> ae_quad_r == $past(pin_s2_r.rd_addr[4:3]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct select ignored");

  property p_mode_fixed;
    cfg_loaded_r |=> $stable(polled_r) && $stable(width36_r);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed");

  property p_pkt_width;
    !width36_r |-> packet_ready_n;
  endproperty
  a_pkt_width: assert property (p_pkt_width) else $error("packet mode narrow");

  property p_pkt_ready;
    !packet_mode ##1 !packet_mode |-> packet_ready_n;
  endproperty
  a_pkt_ready: assert property (p_pkt_ready) else $error("packet ready outside mode");

  property p_capture;
    wr_fire && !rd_fire |=> lvl_r[$past(wq)] == 16'($past(lvl_r[wq]) + 16'h0001);
  endproperty
  a_capture: assert property (p_capture) else $error("write not counted");

  property p_af_load;
    polled_r && wr_tick |=> almost_full_status_bus == ~$past(af_vec[af_quad_nxt*8 +: 8]);
  endproperty
  a_af_load: assert property (p_af_load) else $error("af bus not on wr edge");

  property p_af_direct;
    !polled_r && wr_tick && pin_s2_r.wr_quad_strobe && wr_hit
      |=> af_quad_r == $past(pin_s2_r.wr_addr[4:3]);
  endproperty
  a_af_direct: assert property (p_af_direct) else $error("af direct select ignored");

  property p_ae_hold;
    !polled_r && !(rd_tick && pin_s2_r.rd_quad_strobe) |=> $stable(ae_quad_r);
  endproperty
  a_ae_hold: assert property (p_ae_hold) else $error("direct ae quadrant moved");

  // between ticks the busses must not glitch, users may sample them at any time
  property p_af_quiet;
    !wr_tick |=> $stable(almost_full_status_bus);
  endproperty
  a_af_quiet: assert property (p_af_quiet) else $error("af bus moved without wr edge");

  property p_ae_quiet;
    !rd_tick |=> $stable(almost_empty_status_bus);
  endproperty
  a_ae_quiet: assert property (p_ae_quiet) else $error("ae bus moved without rd edge");

  property p_ready_set;
    packet_mode && rd_hit && pkt_cnt_r[rq] != '0 |=> !packet_ready_n;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("packet ready not shown");

  property p_one_wait;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest low twice");

  c_polled_wrap: cover property (polled_r && wr_tick && af_quad_r == 2'h3);
  c_direct_sel: cover property (!polled_r && wr_tick && pin_s2_r.wr_quad_strobe);
  c_direct_ae: cover property (!polled_r && rd_tick && pin_s2_r.rd_quad_strobe);
  c_pkt_ready: cover property (packet_mode && !packet_ready_n);
  c_pkt_done: cover property (packet_mode && rd_fire && rd_word_end);
endmodule
`default_nettype wire

// file: verif/mqfb_user_model.sv
// user port-side controller model driving the write and read port pins
`timescale 1ns/1ps
`default_nettype none
module mqfb_user_model (
  input wire logic ref_clk,
  output var mqfb_pkg::mqfb_pins_t pins,
  output logic wr_seen,
  output logic rd_seen
);
  initial begin
    pins = '0;
    pins.wr_en_n = 1'b1;
    pins.rd_en_n = 1'b1;
    pins.flag_bus_mode_select = 1'b1;
    wr_seen = 1'b0;
    rd_seen = 1'b0;
  end
  // straps move only while reset is held
  task automatic set_mode(input logic polled, input logic narrow);
    pins.flag_bus_mode_select <= polled;
    pins.width_match_select <= narrow;
  endtask
  // one port clock cycle; port clocks stand low between ticks
  task automatic tick(input logic rd, input logic en_n, input logic [7:0] a,
                      input logic stb, input logic [35:0] d);
    @(posedge ref_clk);
    if (rd) begin
      pins.rd_en_n <= en_n;
      pins.rd_addr <= a;
      pins.rd_quad_strobe <= stb;
    end else begin
      pins.wr_en_n <= en_n;
      pins.wr_addr <= a;
      pins.wr_quad_strobe <= stb;
      pins.din <= d;
    end
    repeat (4) @(posedge ref_clk);
    if (rd) pins.rd_clk <= 1'b1;
    else pins.wr_clk <= 1'b1;
    repeat (6) @(posedge ref_clk);
    if (rd) rd_seen <= 1'b1;
    else wr_seen <= 1'b1;
    @(posedge ref_clk);
    {pins.wr_clk, pins.rd_clk, wr_seen, rd_seen} <= 4'h0;
    {pins.wr_en_n, pins.rd_en_n} <= 2'h3;
    {pins.wr_quad_strobe, pins.rd_quad_strobe} <= 2'h0;
    // data bus driven to the inverse of the word: no stale value left behind
    pins.din <= ~d;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench of the flag bus and packet status block
`timescale 1ns/1ps
`include "mqfb_defines.svh"
`default_nettype none
module testbench;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, rd_word_end;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic [7:0] af_bus, ae_bus;
  logic packet_ready_n, output_valid_n, wr_seen, rd_seen, polled;
  mqfb_pkg::mqfb_pins_t pins;
  logic [31:0] exp_rd[$];
  logic [7:0] exp_af[$];
  logic [7:0] exp_ae[$];
  logic [7:0] q[2][4];
  logic [1:0] s[2];
  int errors, cmp_count, cyc, i;
  mqfb_top dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
    .rd_word_end(rd_word_end), .almost_full_status_bus(af_bus),
    .almost_empty_status_bus(ae_bus), .packet_ready_n(packet_ready_n),
    .output_valid_n(output_valid_n));
  mqfb_user_model u_user (.ref_clk(ref_clk), .pins(pins), .wr_seen(wr_seen),
    .rd_seen(rd_seen));
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] v);
    cmp_count++;
    if (v !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, v);
    end
  endtask
  // bus master: hold the request until waitrequest is sampled low
  task automatic av(input logic wr, input logic [9:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    av(1'b0, a, 32'h0);
  endtask
  // note the quadrant that the tick must load, then make the tick
  task automatic tk(input logic r, input logic en_n, input logic [7:0] a,
                    input logic stb, input logic [35:0] d);
    if (stb) s[r] = a[4:3];
    if (r) exp_ae.push_back(q[1][s[1]]);
    else exp_af.push_back(q[0][s[0]]);
    if (polled) s[r] = s[r] + 2'h1;
    u_user.tick(r, en_n, a, stb, d);
  endtask
  task automatic do_reset(input logic p);
    rst <= 1'b1;
    u_user.set_mode(p, !p);
    polled = p;
    s[0] = 2'h0;
    s[1] = 2'h0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) cmp32("readdata", exp_rd.pop_front(), avs_readdata);
    if (wr_seen) cmp8("af_bus", exp_af.pop_front(), af_bus);
    if (rd_seen) cmp8("ae_bus", exp_ae.pop_front(), ae_bus);
    cyc++;
    if (cyc == 6000) begin
      errors++;
      report_and_stop;
    end
  end
  initial begin
    {rst, avs_read, avs_write, rd_word_end} = 4'h8;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    {errors, cmp_count, cyc, seed} = {32'h0, 32'h0, 32'h0, 32'h0000EC08};
    do_reset(1'b1);
    cmp8("flags", 8'h03, {6'h0, packet_ready_n, output_valid_n});
    cmp8("af_bus", 8'hFF, af_bus);
    rd(`MQFB_REG_STAT, {24'h0, `MQFB_POLL_Q_RST, `MQFB_POLL_Q_RST, 4'h7});
    av(1'b1, `MQFB_REG_CTRL, 32'h0000_2001);
    rd(`MQFB_REG_STAT, {24'h0, `MQFB_POLL_Q_RST, `MQFB_POLL_Q_RST, 4'hF});
    rd(10'h27C, {16'h0, `MQFB_THR_RST});
    rd(10'h008, 32'h0);
    rd(10'h002, 32'h0);
    av(1'b1, 10'h200, 32'h0);
    av(1'b1, 10'h224, 32'h0);
    // a hole above the af table must not alias onto queue 8
    av(1'b1, 10'h2A0, 32'h0);
    rd(10'h220, {16'h0, `MQFB_THR_RST});
    q[0] = '{8'hFE, 8'hFD, 8'hFF, 8'hFF};
    q[1] = '{default: 8'hFF};
    repeat (5) tk(1'b0, 1'b1, 8'h00, 1'b0, 36'h0);
    for (i = 0; i < 3; i++) tk(1'b0, 1'b0, 8'h05, 1'b0, {i == 2, i == 0, 2'h0, rnd()});
    q[1][0] = 8'hDF;
    repeat (4) tk(1'b1, 1'b1, 8'h05, 1'b0, 36'h0);
    cmp8("flags", 8'h00, {6'h0, packet_ready_n, output_valid_n});
    rd(10'h314, 32'h3);
    // drain the packet; the last word read carries the end marker
    for (i = 0; i < 3; i++) begin
      rd_word_end <= i == 2;
      tk(1'b1, 1'b0, 8'h05, 1'b0, 36'h0);
    end
    rd_word_end <= 1'b0;
    cmp8("flags", 8'h03, {6'h0, packet_ready_n, output_valid_n});
    rd(10'h314, 32'h0);
    $display("test polled_packet done");
    do_reset(1'b0);
    // narrow ports: packet enable must not take effect
    av(1'b1, `MQFB_REG_CTRL, 32'h0000_2001);
    rd(`MQFB_REG_STAT, {24'h0, `MQFB_POLL_Q_RST, `MQFB_POLL_Q_RST, 4'h4});
    av(1'b1, 10'h224, 32'h0);
    av(1'b1, 10'h160, 32'h0);
    q[0] = '{8'hFF, 8'hFD, 8'hFF, 8'hFF};
    q[1] = '{default: 8'h00};
    tk(1'b0, 1'b1, 8'h08, 1'b1, 36'h0);
    tk(1'b0, 1'b1, 8'h00, 1'b0, 36'h0);
    tk(1'b0, 1'b1, 8'h00, 1'b1, 36'h0);
    // another device id: the word must not land here
    tk(1'b0, 1'b0, 8'h38, 1'b0, {4'h0, rnd()});
    tk(1'b1, 1'b1, 8'h18, 1'b1, 36'h0);
    tk(1'b0, 1'b0, 8'h18, 1'b0, {4'h0, rnd()});
    q[1][3] = 8'h01;
    tk(1'b1, 1'b1, 8'h00, 1'b0, 36'h0);
    tk(1'b1, 1'b1, 8'h00, 1'b1, 36'h0);
    rd(10'h360, 32'h1);
    $display("test direct done");
    report_and_stop;
  end
endmodule
`default_nettype wire
